// >>> design/fta_table_access.sv
// Table access, holding registers and self-timed program/erase sequencer with AXI4-Lite registers
`default_nettype none
module fta_table_access #(
  parameter int PROG_CYCLES = fta_pkg::PROG_CYCLES_DEF
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // AXI4-Lite slave
  input wire logic [fta_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [fta_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [fta_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [fta_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash array
  output var fta_pkg::fta_flash_req_type flash_req,
  input wire logic [15:0] flash_rd_data,
  // Core instruction fetch
  input wire logic [15:0] fetch_word,
  input wire logic fetch_valid,
  output logic [15:0] instr_word,
  output logic instr_valid,
  output logic fetch_halt
);
  localparam int TMR_W = $clog2(PROG_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(PROG_CYCLES);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(1);
  localparam logic [fta_pkg::PTR_LOW_W-1:0] PTR_ONE = fta_pkg::PTR_LOW_W'(1);

  typedef enum {TS_IDLE, TS_READ, TS_CAPTURE} fta_tbl_state_type;

  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [fta_pkg::DATA_W-1:0] rdata_reg;
  logic cfg_reg, erase_reg, fault_reg, permit_reg, start_reg;
  logic stage1_reg, unlocked_reg;
  logic [7:0] latch_reg;
  logic [fta_pkg::PTR_W-1:0] ptr_reg, op_ptr_reg, addr_reg;
  logic [7:0] hold_reg [fta_pkg::HOLD_N];
  logic [fta_pkg::HOLD_N-1:0] wmask_reg;
  logic rd_en_reg, prog_en_reg, erase_en_reg;
  logic [TMR_W-1:0] timer_reg;
  fta_tbl_state_type ts_reg;
  logic [15:0] instr_reg;
  logic instr_valid_reg;

  logic wr_fire, wr_en, wr_hit, start_req, go, bad, done, store_hit;
  logic [7:0] wd;
  logic [fta_pkg::PTR_W-1:0] ptr_inc, ptr_dec, eff_ptr;
  fta_pkg::fta_ptr_mode_type mode;
  logic [fta_pkg::DATA_W-1:0] rd_mux;
  logic rd_hit, op_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode; writes stall while a table read or a timed cycle runs
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg && ts_reg == TS_IDLE && !start_reg;
  assign wr_en = wr_fire && s_axi_wstrb[0];
  assign wd = s_axi_wdata[7:0];
  assign wr_hit = s_axi_awaddr inside {fta_pkg::OFS_MEM_CTL, fta_pkg::OFS_UNLOCK, fta_pkg::OFS_LATCH,
    fta_pkg::OFS_PTR_LOW, fta_pkg::OFS_PTR_HIGH, fta_pkg::OFS_PTR_UPPER, fta_pkg::OFS_TBL_CMD, fta_pkg::OFS_STATUS};
  assign start_req = wr_en && s_axi_awaddr == fta_pkg::OFS_MEM_CTL && wd[fta_pkg::MC_START];
  assign go = start_req && permit_reg && unlocked_reg;
  assign bad = start_req && !go;
  assign done = start_reg && timer_reg == TMR_LAST;

  // Pointer stepping keeps the space-select bit
  assign ptr_inc = {ptr_reg[fta_pkg::PTR_W-1], ptr_reg[fta_pkg::PTR_LOW_W-1:0] + PTR_ONE};
  assign ptr_dec = {ptr_reg[fta_pkg::PTR_W-1], ptr_reg[fta_pkg::PTR_LOW_W-1:0] - PTR_ONE};
  assign mode = fta_pkg::fta_ptr_mode_type'(wd[fta_pkg::CMD_MODE_LSB +: 2]);
  assign eff_ptr = (mode == fta_pkg::PTR_PRE_INC) ? ptr_inc : ptr_reg;
  assign store_hit = wr_en && s_axi_awaddr == fta_pkg::OFS_TBL_CMD && wd[fta_pkg::CMD_STORE];

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken together, response raised on the same edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= fta_pkg::RESP_OKAY;
    end else if (clk_en) begin
      awready_reg <= wr_fire;
      wready_reg <= wr_fire;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? fta_pkg::RESP_OKAY : fta_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read mux; unlock port has no storage behind it
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      fta_pkg::OFS_MEM_CTL: begin
        rd_mux[fta_pkg::MC_CFG] = cfg_reg;
        rd_mux[fta_pkg::MC_ERASE] = erase_reg;
        rd_mux[fta_pkg::MC_FAULT] = fault_reg;
        rd_mux[fta_pkg::MC_PERMIT] = permit_reg;
        rd_mux[fta_pkg::MC_START] = start_reg;
      end
      fta_pkg::OFS_UNLOCK: rd_mux = '0;
      fta_pkg::OFS_LATCH: rd_mux[7:0] = latch_reg;
      fta_pkg::OFS_PTR_LOW: rd_mux[7:0] = ptr_reg[7:0];
      fta_pkg::OFS_PTR_HIGH: rd_mux[7:0] = ptr_reg[15:8];
      fta_pkg::OFS_PTR_UPPER: rd_mux[5:0] = ptr_reg[fta_pkg::PTR_W-1:16];
      fta_pkg::OFS_TBL_CMD: rd_mux = '0;
      fta_pkg::OFS_STATUS: begin
        rd_mux[fta_pkg::ST_HALT] = start_reg;
        rd_mux[fta_pkg::ST_TBL_BUSY] = ts_reg != TS_IDLE;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel: arready and rvalid rise on the same edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= fta_pkg::RESP_OKAY;
    end else if (clk_en) begin
      arready_reg <= 1'b0;
      if (s_axi_arvalid && !rvalid_reg && !arready_reg) begin
        arready_reg <= 1'b1;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_hit ? fta_pkg::RESP_OKAY : fta_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unlock sequencer; any other write in between breaks the sequence
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage1_reg <= 1'b0;
      unlocked_reg <= 1'b0;
    end else if (clk_en && wr_en) begin
      if (s_axi_awaddr == fta_pkg::OFS_UNLOCK) begin
        stage1_reg <= wd == fta_pkg::KEY_FIRST;
        unlocked_reg <= stage1_reg && wd == fta_pkg::KEY_SECOND;
      end else begin
        stage1_reg <= 1'b0;
        unlocked_reg <= 1'b0;
      end
    end
  end

  // Memory control; there is no bulk-erase control bit at all
  // Fault resets to one: a reset can cut a cycle short and software must see it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_reg <= 1'b0;
      erase_reg <= 1'b0;
      fault_reg <= 1'b1;
      permit_reg <= 1'b0;
      start_reg <= 1'b0;
    end else if (clk_en) begin
      if (done) begin
        start_reg <= 1'b0;
        erase_reg <= 1'b0;
        fault_reg <= 1'b0;
      end else if (bad) begin
        fault_reg <= 1'b1;
        permit_reg <= wd[fta_pkg::MC_PERMIT]; // Config select left alone for tracing
      end else if (wr_en && s_axi_awaddr == fta_pkg::OFS_MEM_CTL) begin
        cfg_reg <= wd[fta_pkg::MC_CFG];
        erase_reg <= wd[fta_pkg::MC_ERASE];
        fault_reg <= wd[fta_pkg::MC_FAULT];
        permit_reg <= wd[fta_pkg::MC_PERMIT];
        start_reg <= go;
      end
    end
  end

  // Programming timer, loaded at launch
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      timer_reg <= '0;
    end else if (clk_en) begin
      if (go) begin
        timer_reg <= TMR_LOAD;
      end else if (start_reg) begin
        timer_reg <= timer_reg - TMR_LAST;
      end
    end
  end

  // Array strobes and address of the timed cycle and of table reads
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prog_en_reg <= 1'b0;
      erase_en_reg <= 1'b0;
      rd_en_reg <= 1'b0;
      addr_reg <= '0;
    end else if (clk_en) begin
      rd_en_reg <= 1'b0;
      if (done) begin
        prog_en_reg <= 1'b0;
        erase_en_reg <= 1'b0;
      end else if (go && wd[fta_pkg::MC_ERASE]) begin
        erase_en_reg <= 1'b1;
        addr_reg <= {ptr_reg[fta_pkg::PTR_W-1:fta_pkg::ROW_SHIFT], {fta_pkg::ROW_SHIFT{1'b0}}};
      end else if (go) begin
        prog_en_reg <= 1'b1;
        addr_reg <= {ptr_reg[fta_pkg::PTR_W-1:fta_pkg::BLOCK_SHIFT], {fta_pkg::BLOCK_SHIFT{1'b0}}};
      end else if (wr_en && s_axi_awaddr == fta_pkg::OFS_TBL_CMD && !wd[fta_pkg::CMD_STORE]) begin
        rd_en_reg <= 1'b1;
        addr_reg <= eff_ptr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table pointer and table transfer sequencing
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ptr_reg <= '0;
      op_ptr_reg <= '0;
      ts_reg <= TS_IDLE;
    end else if (clk_en) begin
      case (ts_reg)
        TS_IDLE: begin
          if (wr_en && s_axi_awaddr == fta_pkg::OFS_PTR_LOW) begin
            ptr_reg[7:0] <= wd;
          end else if (wr_en && s_axi_awaddr == fta_pkg::OFS_PTR_HIGH) begin
            ptr_reg[15:8] <= wd;
          end else if (wr_en && s_axi_awaddr == fta_pkg::OFS_PTR_UPPER) begin
            ptr_reg[fta_pkg::PTR_W-1:16] <= wd[5:0];
          end else if (wr_en && s_axi_awaddr == fta_pkg::OFS_TBL_CMD) begin
            op_ptr_reg <= eff_ptr;
            if (!wd[fta_pkg::CMD_STORE]) begin
              ts_reg <= TS_READ;
            end
            case (mode)
              fta_pkg::PTR_POST_INC, fta_pkg::PTR_PRE_INC: ptr_reg <= ptr_inc;
              fta_pkg::PTR_POST_DEC: ptr_reg <= ptr_dec;
              default: ptr_reg <= ptr_reg;
            endcase
          end
        end
        TS_READ: ts_reg <= TS_CAPTURE;
        TS_CAPTURE: ts_reg <= TS_IDLE;
        default: ts_reg <= TS_IDLE;
      endcase
    end
  end

  // Table latch: written by software or by a table read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      latch_reg <= fta_pkg::ZERO_BYTE;
    end else if (clk_en) begin
      if (ts_reg == TS_CAPTURE) begin
        latch_reg <= op_ptr_reg[0] ? flash_rd_data[15:8] : flash_rd_data[7:0];
      end else if (wr_en && s_axi_awaddr == fta_pkg::OFS_LATCH) begin
        latch_reg <= wd;
      end
    end
  end

  // Holding bytes and their write mask; blank bytes leave flash untouched
  genvar gi;
  generate
    for (gi = 0; gi < fta_pkg::HOLD_N; gi++) begin : g_hold
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          hold_reg[gi] <= fta_pkg::HOLD_BLANK;
          wmask_reg[gi] <= 1'b0;
        end else if (clk_en) begin
          if (done) begin
            hold_reg[gi] <= fta_pkg::HOLD_BLANK;
          end else if (store_hit && eff_ptr[fta_pkg::BLOCK_SHIFT-1:0] == gi) begin
            hold_reg[gi] <= latch_reg;
          end
          if (go) begin
            wmask_reg[gi] <= hold_reg[gi] != fta_pkg::HOLD_BLANK;
          end
        end
      end
      assign flash_req.wdata[gi*8 +: 8] = hold_reg[gi];
    end
  endgenerate

  // Fetch path; a word is delivered only while no timed cycle runs
  assign op_valid = (fetch_word & fta_pkg::RSVD_OP_MASK) != fta_pkg::RSVD_OP_VAL;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      instr_reg <= fta_pkg::NOP_WORD;
      instr_valid_reg <= 1'b0;
    end else if (clk_en) begin
      instr_reg <= (fetch_valid && op_valid) ? fetch_word : fta_pkg::NOP_WORD;
      instr_valid_reg <= fetch_valid && !start_reg && !go;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign flash_req.rd_en = rd_en_reg;
  assign flash_req.prog_en = prog_en_reg;
  assign flash_req.erase_en = erase_en_reg;
  assign flash_req.cfg_sel = cfg_reg;
  assign flash_req.addr = addr_reg;
  assign flash_req.wmask = wmask_reg;
  assign instr_word = instr_reg;
  assign instr_valid = instr_valid_reg;
  assign fetch_halt = start_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst || !clk_en);

  logic all_blank;
  always_comb begin
    all_blank = 1'b1;
    for (int k = 0; k < fta_pkg::HOLD_N; k++) begin
      all_blank = all_blank && hold_reg[k] == fta_pkg::HOLD_BLANK;
    end
  end

  sequence s_read_issue;
    ts_reg == TS_READ ##1 ts_reg == TS_CAPTURE;
  endsequence
  sequence s_launch;
    !start_reg ##1 start_reg;
  endsequence

  property p_launch_gated;
    s_launch |-> $past(permit_reg) && $past(unlocked_reg);
  endproperty
  a_launch_gated: assert property (p_launch_gated) else $error("cycle started without permit or unlock");

  property p_bad_start_fault;
    bad |=> fault_reg && !start_reg;
  endproperty
  a_bad_start_fault: assert property (p_bad_start_fault) else $error("improper start not flagged");

  property p_end_by_timer;
    $fell(start_reg) |-> $past(timer_reg) == TMR_LAST && !fault_reg && !fetch_halt;
  endproperty
  a_end_by_timer: assert property (p_end_by_timer) else $error("cycle ended without timer expiry");

  property p_erase_bit_cleared;
    $fell(start_reg) && $past(erase_en_reg) |-> !erase_reg && !erase_en_reg;
  endproperty
  a_erase_bit_cleared: assert property (p_erase_bit_cleared) else $error("erase bit survived erase");

  property p_top_bit_kept;
    !(wr_en && s_axi_awaddr == fta_pkg::OFS_PTR_UPPER) |=> $stable(ptr_reg[fta_pkg::PTR_W-1]);
  endproperty
  a_top_bit_kept: assert property (p_top_bit_kept) else $error("pointer step changed space bit");

  property p_hold_blank_after;
    $fell(start_reg) |-> all_blank;
  endproperty
  a_hold_blank_after: assert property (p_hold_blank_after) else $error("holding bytes not blank after cycle");

  property p_cfg_kept_on_fault;
    bad |=> fault_reg && $stable(cfg_reg);
  endproperty
  a_cfg_kept_on_fault: assert property (p_cfg_kept_on_fault) else $error("config select moved on fault");

  property p_byte_select;
    s_read_issue |=> latch_reg == ($past(op_ptr_reg[0]) ? $past(flash_rd_data[15:8]) : $past(flash_rd_data[7:0]));
  endproperty
  a_byte_select: assert property (p_byte_select) else $error("wrong byte loaded into latch");

  property p_unlock_reads_zero;
    s_axi_arvalid && !rvalid_reg && !arready_reg && s_axi_araddr == fta_pkg::OFS_UNLOCK |=> rdata_reg == '0;
  endproperty
  a_unlock_reads_zero: assert property (p_unlock_reads_zero) else $error("unlock port read nonzero");

  property p_halt_blocks_fetch;
    start_reg |=> !instr_valid;
  endproperty
  a_halt_blocks_fetch: assert property (p_halt_blocks_fetch) else $error("fetch delivered during timed cycle");

  property p_nop_substitute;
    fetch_valid && !op_valid |=> instr_word == fta_pkg::NOP_WORD;
  endproperty
  a_nop_substitute: assert property (p_nop_substitute) else $error("invalid word not replaced");

endmodule // fta_table_access
`default_nettype wire

// >>> inc/fta_pkg.sv
// Package: register map, field positions, timing and carrier types for the table access block
`default_nettype none
package fta_pkg;
  // Register bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_MEM_CTL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_UNLOCK = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_LATCH = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_PTR_LOW = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_PTR_HIGH = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_PTR_UPPER = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_TBL_CMD = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h1C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Memory control field positions
  localparam int MC_START = 1;
  localparam int MC_PERMIT = 2;
  localparam int MC_FAULT = 3;
  localparam int MC_ERASE = 4;
  localparam int MC_CFG = 6;
  // Table command field positions
  localparam int CMD_MODE_LSB = 0;
  localparam int CMD_STORE = 2;
  // Status field positions
  localparam int ST_HALT = 0;
  localparam int ST_TBL_BUSY = 1;
  // Unlock keys
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // Pointer and holding geometry
  localparam int PTR_W = 22;
  localparam int PTR_LOW_W = 21;
  localparam int HOLD_N = 16;
  localparam int BLOCK_SHIFT = 4;
  localparam int ROW_SHIFT = 6;
  localparam logic [7:0] HOLD_BLANK = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // Self-timed cycle: about 2 ms at a 5 ns clock
  localparam int PROG_TIME_NS = 2000000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
  // Instruction substitution; reserved opcode pattern is arbitrary
  localparam logic [15:0] NOP_WORD = 16'h0000;
  localparam logic [15:0] RSVD_OP_MASK = 16'hFF00;
  localparam logic [15:0] RSVD_OP_VAL = 16'h0100;
  // Pointer actions of a table transfer
  typedef enum logic [1:0] {PTR_KEEP, PTR_POST_INC, PTR_POST_DEC, PTR_PRE_INC} fta_ptr_mode_type;
  // Request bundle toward the flash array
  typedef struct packed {
    logic rd_en;
    logic prog_en;
    logic erase_en;
    logic cfg_sel;
    logic [PTR_W-1:0] addr;
    logic [HOLD_N-1:0] wmask;
    logic [HOLD_N*8-1:0] wdata;
  } fta_flash_req_type;
endpackage
`default_nettype wire

// >>> verification/fta_flash_model.sv
// Flash array model behind the table access block
`default_nettype none
module fta_flash_model (
  // Clock
  input wire logic sys_clk,
  // Array request and read data
  input wire fta_pkg::fta_flash_req_type flash_req,
  output logic [15:0] flash_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];
  logic prog_q;
  logic erase_q;
  // Distinct byte pattern so a wrong byte lane shows up
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    flash_rd_data = 16'h0000;
    prog_q = 1'b0;
    erase_q = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Word one cycle after request, scrambled otherwise so stale data is never reused
  always @(posedge sys_clk) begin
    prog_q <= flash_req.prog_en;
    erase_q <= flash_req.erase_en;
    if (flash_req.rd_en) begin
      flash_rd_data <= {mem[{flash_req.addr[6:1], 1'b1}], mem[{flash_req.addr[6:1], 1'b0}]};
    end else begin
      flash_rd_data <= ~flash_rd_data;
    end
    // Masked bytes take the holding value outright, so a stray mask bit shows up as FFh
    if (flash_req.prog_en && !prog_q) begin
      for (int i = 0; i < 16; i++) begin
        if (flash_req.wmask[i]) begin
          mem[{flash_req.addr[6:4], 4'(i)}] = flash_req.wdata[i*8+:8];
        end
      end
    end
    if (flash_req.erase_en && !erase_q) begin
      for (int i = 0; i < 64; i++) begin
        mem[{flash_req.addr[6], 6'(i)}] = 8'hFF;
      end
    end
  end
endmodule // fta_flash_model
`default_nettype wire

// >>> verification/fta_table_access_tb_top.sv
// Self-checking bench for the table access block
`default_nettype none
module fta_table_access_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [4:0] s_axi_awaddr = 5'h00;
  logic [4:0] s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, instr_valid, fetch_halt;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  fta_pkg::fta_flash_req_type flash_req;
  logic [15:0] flash_rd_data, instr_word;
  logic [15:0] fetch_word = 16'h0000;
  logic fetch_valid = 1'b0;
  int bad_count = 0;
  int comparisons = 0;
  // Short timed cycle keeps the run brief
  fta_table_access #(.PROG_CYCLES(8)) uut (.sys_clk, .sys_rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .flash_req, .flash_rd_data, .fetch_word, .fetch_valid, .instr_word, .instr_valid, .fetch_halt);
  fta_flash_model flash (.sys_clk, .flash_req, .flash_rd_data);
  always #2.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus write: both channels offered, each released when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk); // Idle edge so back-to-back calls never reassign a valid in one step
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge sys_clk); // Idle edge so back-to-back calls never reassign a valid in one step
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic setp(input logic [21:0] p);
    wr(fta_pkg::OFS_PTR_LOW, {24'h0, p[7:0]});
    wr(fta_pkg::OFS_PTR_HIGH, {24'h0, p[15:8]});
    wr(fta_pkg::OFS_PTR_UPPER, {26'h0, p[21:16]});
  endtask
  task automatic ptr_chk(input logic [21:0] e);
    logic [31:0] l, h, u;
    rd(fta_pkg::OFS_PTR_LOW, l);
    rd(fta_pkg::OFS_PTR_HIGH, h);
    rd(fta_pkg::OFS_PTR_UPPER, u);
    chk({10'h0, u[5:0], h[7:0], l[7:0]}, {10'h0, e});
  endtask
  // Table fetch; latch lands two cycles after the command is taken
  task automatic fetch(input logic [21:0] p, input logic [31:0] m);
    setp(p);
    wr(fta_pkg::OFS_TBL_CMD, m);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic go(input logic [31:0] mc);
    wr(fta_pkg::OFS_UNLOCK, {24'h0, fta_pkg::KEY_FIRST});
    wr(fta_pkg::OFS_UNLOCK, {24'h0, fta_pkg::KEY_SECOND});
    wr(fta_pkg::OFS_MEM_CTL, mc);
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    do rd(fta_pkg::OFS_STATUS, s); while (s[0] !== 1'b0);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rdc(fta_pkg::OFS_MEM_CTL, 32'h08);
    wr(fta_pkg::OFS_UNLOCK, 32'h55);
    rdc(fta_pkg::OFS_UNLOCK, 32'h0);
    wr(5'h01, 32'h0);
    chk(s_axi_bresp, fta_pkg::RESP_SLVERR);
    $display("test registers done");
    // Every pointer action at the 21-bit wrap point
    for (int m = 0; m < 4; m++) begin
      fetch(22'h3FFFFF, 32'(m));
      rdc(fta_pkg::OFS_LATCH, m == 3 ? 32'h5A : 32'h25);
      ptr_chk(m == 0 ? 22'h3FFFFF : m == 2 ? 22'h3FFFFE : 22'h200000);
    end
    $display("test pointer done");
    // Store one byte, refused start, then a proper block write
    setp(22'h000025);
    wr(fta_pkg::OFS_LATCH, 32'hC3);
    wr(fta_pkg::OFS_TBL_CMD, 32'h5);
    ptr_chk(22'h000026);
    wr(fta_pkg::OFS_MEM_CTL, 32'h44);
    chk(flash_req.cfg_sel, 32'h1);
    wr(fta_pkg::OFS_MEM_CTL, 32'h06);
    rdc(fta_pkg::OFS_MEM_CTL, 32'h4C);
    rdc(fta_pkg::OFS_STATUS, 32'h0);
    wr(fta_pkg::OFS_MEM_CTL, 32'h04);
    fetch_valid <= 1'b1;
    go(32'h06);
    rdc(fta_pkg::OFS_STATUS, 32'h1);
    chk(fetch_halt, 32'h1);
    chk(instr_valid, 32'h0);
    wait_idle();
    rdc(fta_pkg::OFS_MEM_CTL, 32'h04);
    fetch(22'h000025, 32'h0);
    rdc(fta_pkg::OFS_LATCH, 32'hC3);
    fetch(22'h000024, 32'h0);
    rdc(fta_pkg::OFS_LATCH, 32'h7E);
    // Second write with no stores must leave the next block alone
    setp(22'h000040);
    go(32'h06);
    wait_idle();
    $display("test program done");
    // Row erase, low pointer bits ignored
    setp(22'h000023);
    go(32'h16);
    wait_idle();
    rdc(fta_pkg::OFS_MEM_CTL, 32'h04);
    fetch(22'h000010, 32'h0);
    rdc(fta_pkg::OFS_LATCH, 32'hFF);
    fetch(22'h000045, 32'h0);
    rdc(fta_pkg::OFS_LATCH, 32'h1F);
    $display("test erase done");
    // Reset cutting a timed cycle short leaves the fault flag set
    go(32'h06);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdc(fta_pkg::OFS_MEM_CTL, 32'h08);
    chk(fetch_halt, 32'h0);
    go(32'h06);
    rdc(fta_pkg::OFS_MEM_CTL, 32'h0C);
    $display("test reset done");
    // Reserved opcode pattern turns into a no-operation
    for (int i = 0; i < 2; i++) begin
      fetch_word <= i ? 16'h01AB : 16'h1234;
      repeat (2) @(posedge sys_clk);
      chk(instr_word, i ? 32'h0 : 32'h1234);
      chk(instr_valid, 32'h1);
    end
    $display("test fetch done");
    end_of_test();
  end
endmodule // fta_table_access_tb_top
`default_nettype wire
